// ==== ifb_bank.sv ====
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/10ps
// Summary of operation
// - Bit 7 of first register is serial-port request flag, read/write.
// - Bit 6 of first register is serial-module request flag, read/write.
// - Bits 5 and 4 are external pin 1 and time base 1 flags.
// - Bits 3..0 of first register enable those four sources, 1 enables.
// - Second register: standard timer A/P flags bits 5/4, enables 1/0.
// - Unused bits of second and fourth registers read zero, writes ignored.
// - Third register: compact A/P flags bits 7/6, periodic A/P bits 5/4.
// - Third register bits 3..0 enable compact A/P and periodic A/P.
// - Fourth register: eeprom flag bit 5, low-voltage bit 4, enables 1/0.
// - Low-voltage enable gates only forwarding, flag still records the event.
// - Events always set flags; forwarding needs own enable and global enable.
// - Group flag set by enabled member event; members stay set until cleared.
// - Core acknowledge clears that request's flag and the global enable.
module ifb_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral event pulses
  input wire logic [ifb_pkg::NSRC-1:0] src_event,
  // Core request and acknowledge
  input wire logic [ifb_pkg::NREQ-1:0] core_ack,
  output logic [ifb_pkg::NREQ-1:0] core_req,
  output logic global_irq_enable,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_index(input logic [7:0] a);
    case (a)
      ifb_pkg::OFS_SERIAL: reg_index = ifb_pkg::IDX_SERIAL;
      ifb_pkg::OFS_STD: reg_index = ifb_pkg::IDX_STD;
      ifb_pkg::OFS_CMPPER: reg_index = ifb_pkg::IDX_CMPPER;
      ifb_pkg::OFS_EEPLV: reg_index = ifb_pkg::IDX_EEPLV;
      ifb_pkg::OFS_GROUP: reg_index = ifb_pkg::IDX_GROUP;
      ifb_pkg::OFS_STAT: reg_index = ifb_pkg::IDX_STAT;
      ifb_pkg::OFS_MASK: reg_index = ifb_pkg::IDX_MASK;
      default: reg_index = ifb_pkg::IDX_NONE;
    endcase
  endfunction

  logic [ifb_pkg::NSRC-1:0] flag_r;
  logic [ifb_pkg::NSRC-1:0] flag_nxt;
  logic [ifb_pkg::NSRC-1:0] en_r;
  logic [ifb_pkg::NSRC-1:0] en_nxt;
  logic [ifb_pkg::NSRC-1:0] mset;
  logic [ifb_pkg::NGRP-1:0] gflag_r;
  logic [ifb_pkg::NGRP-1:0] gflag_nxt;
  logic [ifb_pkg::NGRP-1:0] gen_r;
  logic [ifb_pkg::NGRP-1:0] gen_nxt;
  logic [ifb_pkg::NGRP-1:0] gset;
  logic gie_r;
  logic gie_nxt;
  logic [ifb_pkg::NSTAT-1:0] stat_r;
  logic [ifb_pkg::NSTAT-1:0] stat_nxt;
  logic [ifb_pkg::NSTAT-1:0] mask_r;
  logic [ifb_pkg::NSTAT-1:0] mask_nxt;
  logic [31:0] prdata_r;
  logic [7:0] rbank [4];
  logic [7:0] rdata;

  wire [2:0] widx = reg_index(paddr);
  wire mapped = widx != ifb_pkg::IDX_NONE;
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr = access && pwrite && mapped;
  wire wgrp = wr && widx == ifb_pkg::IDX_GROUP;
  wire wstat = wr && widx == ifb_pkg::IDX_STAT;
  wire wmask = wr && widx == ifb_pkg::IDX_MASK;

  // Zero wait states; an unmapped word answers with an error
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = prdata_r;

  // ----------------------------------------------------------------
  // Per-source flag and enable
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < ifb_pkg::NSRC; i++) begin : g_src
      localparam int FB = ifb_pkg::SRC_FBIT[i];
      localparam int EB = ifb_pkg::SRC_EBIT[i];
      wire wsel = wr && widx == ifb_pkg::SRC_REG[i];
      // Only own-vector sources are cleared by service; members are not
      wire aclr;
      if (ifb_pkg::DIR_MASK[i]) begin : g_dir
        assign aclr = core_ack[i];
      end else begin : g_mem
        assign aclr = 1'b0;
      end
      // Event ORed last so it beats a write of zero
      assign flag_nxt[i] = src_event[i] | (wsel ? pwdata[FB] : (flag_r[i] & ~aclr));
      assign en_nxt[i] = wsel ? pwdata[EB] : en_r[i];
      // A member's enable only gates the group, never the recording
      assign mset[i] = src_event[i] & en_r[i] & ~ifb_pkg::DIR_MASK[i];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Group flags, global enable and forwarding
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < ifb_pkg::NGRP; g++) begin : g_grp
      assign gset[g] = |(mset & ifb_pkg::GRP_MASK[g]);
      assign gflag_nxt[g] = gset[g] |
        (wgrp ? pwdata[ifb_pkg::GRP_FLAG_LSB+g] : (gflag_r[g] & ~core_ack[ifb_pkg::NDIR+g]));
      assign gen_nxt[g] = wgrp ? pwdata[ifb_pkg::GRP_EN_LSB+g] : gen_r[g];
      assign core_req[ifb_pkg::NDIR+g] = gflag_r[g] & gen_r[g] & gie_r;
    end
    for (i = 0; i < ifb_pkg::NDIR; i++) begin : g_dreq
      assign core_req[i] = flag_r[i] & en_r[i] & gie_r;
    end
  endgenerate

  // Service beats a same-cycle software set to block nesting
  assign gie_nxt = (|core_ack) ? 1'b0 : (wgrp ? pwdata[ifb_pkg::GIE_BIT] : gie_r);
  assign global_irq_enable = gie_r;

  // ----------------------------------------------------------------
  // Status, mask and interrupt
  // ----------------------------------------------------------------
  wire [ifb_pkg::NSTAT-1:0] stat_evt = {|src_event, |core_ack};
  wire [ifb_pkg::NSTAT-1:0] stat_w1c = wstat ? pwdata[ifb_pkg::NSTAT-1:0] : '0;
  assign stat_nxt = stat_evt | (stat_r & ~stat_w1c);
  assign mask_nxt = wmask ? pwdata[ifb_pkg::NSTAT-1:0] : mask_r;
  assign irq = |(stat_r & mask_r);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Unplaced positions stay zero, so reserved bits read as zero
  always_comb begin
    for (int r = 0; r < 4; r++) begin
      rbank[r] = ifb_pkg::REG_RST;
    end
    for (int s = 0; s < ifb_pkg::NSRC; s++) begin
      rbank[ifb_pkg::SRC_REG[s][1:0]][ifb_pkg::SRC_FBIT[s]] = flag_r[s];
      rbank[ifb_pkg::SRC_REG[s][1:0]][ifb_pkg::SRC_EBIT[s]] = en_r[s];
    end
  end

  wire [7:0] grp_rd = {gie_r, gen_r, 1'b0, gflag_r};
  wire [7:0] stat_rd = {{(8-ifb_pkg::NSTAT){1'b0}}, stat_r};
  wire [7:0] mask_rd = {{(8-ifb_pkg::NSTAT){1'b0}}, mask_r};
  assign rdata = (widx == ifb_pkg::IDX_GROUP) ? grp_rd :
                 (widx == ifb_pkg::IDX_STAT) ? stat_rd :
                 (widx == ifb_pkg::IDX_MASK) ? mask_rd :
                 (widx == ifb_pkg::IDX_NONE) ? ifb_pkg::REG_RST : rbank[widx[1:0]];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_r <= '0;
      en_r <= '0;
      gflag_r <= '0;
      gen_r <= '0;
      gie_r <= 1'b0;
      stat_r <= '0;
      mask_r <= '0;
    end else begin
      flag_r <= flag_nxt;
      en_r <= en_nxt;
      gflag_r <= gflag_nxt;
      gen_r <= gen_nxt;
      gie_r <= gie_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
    end
  end

  // Read data captured in setup, held through access
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata_r <= '0;
    end else if (setup) begin
      prdata_r <= {24'h000000, rdata};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  wire quiet = !(|src_event) && !(|core_ack);

  reg0_layout_a: assert property (wr && widx == ifb_pkg::IDX_SERIAL && quiet |=>
    {flag_r[0], flag_r[1], flag_r[2], flag_r[3], en_r[0], en_r[1], en_r[2], en_r[3]} == $past(pwdata[7:0]))
    else $error("first register layout wrong");

  reg1_layout_a: assert property (wr && widx == ifb_pkg::IDX_STD && quiet |=>
    {flag_r[4], flag_r[5], en_r[4], en_r[5]} == {$past(pwdata[5:4]), $past(pwdata[1:0])})
    else $error("second register layout wrong");

  reg2_layout_a: assert property (wr && widx == ifb_pkg::IDX_CMPPER && quiet |=>
    {flag_r[6], flag_r[7], flag_r[8], flag_r[9], en_r[6], en_r[7], en_r[8], en_r[9]} == $past(pwdata[7:0]))
    else $error("third register layout wrong");

  reg3_layout_a: assert property (wr && widx == ifb_pkg::IDX_EEPLV && quiet |=>
    {flag_r[10], flag_r[11], en_r[10], en_r[11]} == {$past(pwdata[5:4]), $past(pwdata[1:0])})
    else $error("fourth register layout wrong");

  reserved_zero_a: assert property (setup && (paddr == ifb_pkg::OFS_STD || paddr == ifb_pkg::OFS_EEPLV) |=>
    prdata[7:6] == 2'b00 && prdata[3:2] == 2'b00)
    else $error("reserved bits not zero");

  lv_record_a: assert property (src_event[11] && !en_r[11] && !src_event[10] && !gflag_r[2] && !wgrp |=>
    flag_r[11] && !gflag_r[2])
    else $error("low-voltage gating wrong");

  req_forward_a: assert property (src_event[0] && en_r[0] && gie_r && quiet && !wr |=>
    core_req[0] ##1 core_req[0] || !gie_r || !en_r[0] || !flag_r[0])
    else $error("request not forwarded");

  group_set_a: assert property (src_event[6] && en_r[6] |=> gflag_r[1])
    else $error("group flag not set");

  member_sticky_a: assert property (flag_r[6] && !(wr && widx == ifb_pkg::IDX_CMPPER) |=> flag_r[6])
    else $error("member flag lost");

  ack_clear_a: assert property (core_ack[0] && !src_event[0] && !(wr && widx == ifb_pkg::IDX_SERIAL) |=>
    !flag_r[0] && !gie_r)
    else $error("service did not clear");

  ack_gie_a: assert property ((|core_ack) |=> !gie_r [*1] ##1 (gie_r -> $past(wgrp)))
    else $error("global enable not cleared");

  set_wins_a: assert property (src_event[2] && wr && widx == ifb_pkg::IDX_SERIAL && !pwdata[5] |=> flag_r[2])
    else $error("event lost to clear");

  req_served_c: cover property (core_req[0] ##1 core_ack[0] ##1 !gie_r);
  group_served_c: cover property (gflag_r[1] && core_req[5] ##1 core_ack[5]);
  race_c: cover property (src_event[1] && wr && widx == ifb_pkg::IDX_SERIAL);
  irq_c: cover property (irq ##1 wstat);
  lv_fwd_c: cover property (src_event[11] && en_r[11] ##1 gflag_r[2]);

  // ----------------------------------------------------------------
  // Recording, hold, read, forwarding and service checks
  // ----------------------------------------------------------------
  // Hold checks cover writes landing on the wrong word

  tb_flag_set_a: assert property (src_event[3] |=> flag_r[3])
    else $error("time base flag not set");

  std_flag_set_a: assert property (src_event[5] |=> flag_r[5])
    else $error("standard timer flag not set");

  cp_flag_set_a: assert property (src_event[7] |=> flag_r[7])
    else $error("compact timer flag not set");

  per_flag_set_a: assert property (src_event[9] |=> flag_r[9])
    else $error("periodic timer flag not set");

  ee_flag_set_a: assert property (src_event[10] |=> flag_r[10])
    else $error("eeprom flag not set");

  pin_flag_hold_a: assert property (flag_r[2] && !core_ack[2] && !(wr && widx == ifb_pkg::IDX_SERIAL) |=>
    flag_r[2])
    else $error("pin flag lost");

  en_serial_hold_a: assert property (!(wr && widx == ifb_pkg::IDX_SERIAL) |=>
    en_r[3:0] == $past(en_r[3:0]))
    else $error("serial enables changed");

  en_std_hold_a: assert property (!(wr && widx == ifb_pkg::IDX_STD) |=>
    en_r[5:4] == $past(en_r[5:4]))
    else $error("standard timer enables changed");

  en_cp_hold_a: assert property (!(wr && widx == ifb_pkg::IDX_CMPPER) |=>
    en_r[9:6] == $past(en_r[9:6]))
    else $error("timer enables changed");

  en_ee_hold_a: assert property (!(wr && widx == ifb_pkg::IDX_EEPLV) |=>
    en_r[11:10] == $past(en_r[11:10]))
    else $error("eeprom enables changed");

  upper_zero_a: assert property (access |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  lv_forward_a: assert property (src_event[11] && en_r[11] |=> gflag_r[2])
    else $error("low-voltage not forwarded");

  req_gated_a: assert property (!gie_r |-> core_req == '0)
    else $error("request without global enable");

  req_enable_a: assert property (!en_r[1] |-> !core_req[1])
    else $error("request without own enable");

  tb_req_a: assert property (flag_r[3] && en_r[3] && gie_r |-> core_req[3])
    else $error("time base request missing");

  grp_req_a: assert property (gflag_r[0] && gen_r[0] && gie_r |-> core_req[4])
    else $error("group request missing");

  member_no_ack_a: assert property (flag_r[4] && core_ack[4] && !(wr && widx == ifb_pkg::IDX_STD) |=>
    flag_r[4])
    else $error("member cleared by service");

  grp_ack_clear_a: assert property (core_ack[5] && !gset[1] && !wgrp |=> !gflag_r[1])
    else $error("group flag not cleared");

  gie_hold_a: assert property (gie_r && !(|core_ack) && !wgrp |=> gie_r)
    else $error("global enable dropped");

  ack_wins_a: assert property ((|core_ack) && wgrp && pwdata[ifb_pkg::GIE_BIT] |=> !gie_r)
    else $error("software set beat service");

  ack_race_a: assert property (src_event[1] && core_ack[1] |=> flag_r[1])
    else $error("event lost to service");

  grp_race_a: assert property (gset[2] && wgrp && !pwdata[ifb_pkg::GRP_FLAG_LSB+2] |=> gflag_r[2])
    else $error("group event lost to clear");

endmodule

// ==== ifb_pkg.sv ====
package ifb_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NSRC = 12;
  localparam int NGRP = 3;
  localparam int NDIR = 4;
  localparam int NREQ = 7;
  localparam int NSTAT = 2;

  // ----------------------------------------------------------------
  // Byte offsets and register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SERIAL = 8'h00;
  localparam logic [7:0] OFS_STD = 8'h04;
  localparam logic [7:0] OFS_CMPPER = 8'h08;
  localparam logic [7:0] OFS_EEPLV = 8'h0C;
  localparam logic [7:0] OFS_GROUP = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;

  localparam logic [2:0] IDX_SERIAL = 3'h0;
  localparam logic [2:0] IDX_STD = 3'h1;
  localparam logic [2:0] IDX_CMPPER = 3'h2;
  localparam logic [2:0] IDX_EEPLV = 3'h3;
  localparam logic [2:0] IDX_GROUP = 3'h4;
  localparam logic [2:0] IDX_STAT = 3'h5;
  localparam logic [2:0] IDX_MASK = 3'h6;
  localparam logic [2:0] IDX_NONE = 3'h7;

  // ----------------------------------------------------------------
  // Source layout: 0 serial port, 1 serial module, 2 ext pin 1,
  // 3 time base 1, 4/5 standard A/P, 6/7 compact A/P,
  // 8/9 periodic A/P, 10 eeprom done, 11 low voltage
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_REG [NSRC] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1,
                                           3'h2, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3};
  localparam int SRC_FBIT [NSRC] = '{7, 6, 5, 4, 5, 4, 7, 6, 5, 4, 5, 4};
  localparam int SRC_EBIT [NSRC] = '{3, 2, 1, 0, 1, 0, 3, 2, 1, 0, 1, 0};
  localparam logic [NSRC-1:0] DIR_MASK = 12'h00F;
  localparam logic [NSRC-1:0] GRP_MASK [NGRP] = '{12'h030, 12'h3C0, 12'hC00};

  // ----------------------------------------------------------------
  // Group register and status fields
  // ----------------------------------------------------------------
  localparam int GRP_FLAG_LSB = 0;
  localparam int GRP_EN_LSB = 4;
  localparam int GIE_BIT = 7;
  localparam int ST_ACK = 0;
  localparam int ST_EVT = 1;
  localparam logic [7:0] REG_RST = 8'h00;

endpackage

// ==== ifb_core_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Core acknowledge model
// ----------------------------------------------------------------
module ifb_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Bench control
  input wire logic ack_en,
  input wire logic [3:0] slow,
  // Request and acknowledge
  input wire logic [ifb_pkg::NREQ-1:0] core_req,
  output logic [ifb_pkg::NREQ-1:0] core_ack
);
  logic [3:0] cnt_r;
  // Lowest index served first; real priority is not modelled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 4'h0;
      core_ack <= '0;
    end else if (core_ack != '0 || !ack_en || core_req == '0) begin
      cnt_r <= 4'h0;
      core_ack <= '0;
    end else if (cnt_r == slow) begin
      cnt_r <= 4'h0;
      core_ack <= core_req & (~core_req + 7'h01);
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

// ==== test_irq_flag_enable_bank.sv ====
`timescale 1ns/10ps
module test_irq_flag_enable_bank;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ack_en = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [31:0] seed = 32'h00016577;
  logic pready, pslverr, err, gie, irq;
  logic [3:0] slow = 4'h0;
  logic [11:0] src_event = 12'h000;
  logic [6:0] core_req, core_ack;
  int bad_count = 0, n_compared = 0;

  always #5 clk = ~clk;

  ifb_bank uut (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_event(src_event), .core_ack(core_ack), .core_req(core_req),
    .global_irq_enable(gie), .irq(irq));
  ifb_core_model cm (.clk(clk), .resetn(resetn), .ack_en(ack_en), .slow(slow),
    .core_req(core_req), .core_ack(core_ack));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Reserved bits of the timer and eeprom registers never stick
  function logic [31:0] wmask(input int r);
    return (r == 1 || r == 3) ? 32'h33 : 32'hFF;
  endfunction
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask
  // Event rides the access cycle so it meets the write at one edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [11:0] ev);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    src_event <= ev;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      src_event <= '0;
      n++;
      @(posedge clk);
    end
    if (n == 20) chk("pready", 1, 0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    src_event <= '0;
  endtask
  task w(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 12'h000);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 12'h000);
    chk($sformatf("reg %h", a), exp, rd);
  endtask
  task pulse(input int i);
    @(posedge clk);
    src_event <= 12'h001 << i;
    @(posedge clk);
    src_event <= '0;
    @(negedge clk);
  endtask
  task wait_idle;
    int n;
    n = 0;
    while (core_req !== 7'h00 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk("core_req idle", 0, {25'h0, core_req});
  endtask
  task chk_irq(input logic e);
    @(negedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      rc(8'(r * 4), 32'h0);
      w(8'(r * 4), 32'hFF);
      rc(8'(r * 4), wmask(r));
    end
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      w(8'(seed[1:0] * 4), {24'h0, seed[15:8]});
      rc(8'(seed[1:0] * 4), {24'h0, seed[15:8]} & wmask(int'(seed[1:0])));
    end
    for (int r = 0; r < 5; r++) w(8'(r * 4), 32'h0);
    for (int i = 0; i < 12; i++) begin
      pulse(i);
      rc(8'(ifb_pkg::SRC_REG[i] * 4), 32'h1 << ifb_pkg::SRC_FBIT[i]);
      w(8'(ifb_pkg::SRC_REG[i] * 4), 32'h0);
    end
    w(8'h00, 32'h08);
    w(8'h10, 32'h80);
    pulse(0);
    chk("core_req", 32'h01, {25'h0, core_req});
    slow <= seed[3:0];
    ack_en <= 1'b1;
    wait_idle;
    chk("gie", 32'h0, {31'h0, gie});
    rc(8'h00, 32'h08);
    ack_en <= 1'b0;
    w(8'h04, 32'h02);
    w(8'h10, 32'h90);
    pulse(4);
    chk("core_req", 32'h10, {25'h0, core_req});
    rc(8'h10, 32'h91);
    slow <= 4'h0;
    ack_en <= 1'b1;
    wait_idle;
    rc(8'h04, 32'h22);
    rc(8'h10, 32'h10);
    w(8'h0C, 32'h0);
    w(8'h10, 32'hC0);
    pulse(11);
    rc(8'h0C, 32'h10);
    rc(8'h10, 32'hC0);
    chk("core_req", 32'h0, {25'h0, core_req});
    apb(1'b1, 8'h00, 32'h0, 12'h002);
    rc(8'h00, 32'h40);
    w(8'h14, 32'h3);
    rc(8'h14, 32'h0);
    w(8'h18, 32'h2);
    pulse(3);
    chk_irq(1'b1);
    rc(8'h14, 32'h2);
    w(8'h18, 32'h0);
    chk_irq(1'b0);
    w(8'h18, 32'h2);
    w(8'h14, 32'h2);
    chk_irq(1'b0);
    rc(8'h14, 32'h0);
    apb(1'b1, 8'h1C, 32'hFF, 12'h000);
    chk("pslverr", 32'h1, {31'h0, err});
    rc(8'h1C, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    give_verdict;
  end

  // Whole run is well under a thousand cycles
  initial begin
    #50000;
    bad_count++;
    give_verdict;
  end
endmodule
